// *** hdl/lane_framer.sv ***
// Transmit lane mapper and test-pattern source for a two-link serial output.
// Assumes one octet per lane per clk_sys edge and a same-clock link layer
// that reports the end of its alignment sequence on ila_done.
//
// Overview of operation
// - 12-bit dec-4, 16 lanes: even lanes I, odd Q, five samples plus tail.
// - 15-bit dec-8, 2 lanes: lane 0 sends I then Q, link B mirrors.
// - 15-bit dec-8, 4 lanes: lane 0 carries I, lane 1 carries Q.
// - 15-bit dec-16, 1 lane: link A lane 0 sends AI, AQ, BI, BQ.
// - 15-bit dec-16, 2 lanes: each link lane 0 sends I then Q.
// - 8-bit single channel: link A lane k sample 2k, link B 2k+1.
// - 8-bit dual channel: link A lane k A sample k, link B B sample k.
// - Route select feeds one channel to both down-converters.
// - Unused converter powers down under binding when its bit is set.
// - Route select duplicates one channel on both links, not single-channel formats.
// - Full power-down pin or operating state disables every output driver.
// - Operating state other than 0x00 or 0x01 powers down all serializers.
// - Channel power-down bit powers down that converter and its lanes.
// - Lanes beyond the format's count are powered down on each link.
// - Keep-alive bits keep spare lanes powered and toggling.
// - Pattern select picks the stream; lane power never depends on the pattern.
// - PRBS bits go out unencoded, each lane at its own phase.
// - PRBS7 bit is XOR of bits six and seven back.
// - PRBS15 uses taps 14,15; PRBS23 uses taps 18,23.
// - Ramp sends identical incrementing octet on all powered in-use lanes after alignment.
`timescale 1ns/1ps
`include "lane_framer_consts.svh"

module lane_framer #(
  parameter int LANES = 16
) (
  // Clock and reset
  input  wire logic                         clk_sys,
  input  wire logic                         nrst,
  // Configuration and pins
  input  wire lane_framer_pkg::cfg_t        cfg,
  input  wire logic                         full_powerdown_pin,
  input  wire logic                         ila_done,
  // Sample frames
  input  wire lane_framer_pkg::frame_in_t   frame_in,
  output logic                              frame_take_ff,
  // Lane outputs
  output lane_framer_pkg::lane_octets_t     lane_data_ff,
  output logic [15:0]                       lane_power_ff,
  output logic                              frame_start_ff,
  // Converter and down-converter control
  output logic [1:0]                        conv_power_ff,
  output logic                              ddc_b_from_a_ff,
  output logic                              ddc_a_from_b_ff
);

  initial begin
    if (LANES != 16) begin
      $error("lane_framer serves exactly sixteen lanes");
    end
  end

  // ------------------------------------------------------------------
  // Pin synchroniser and power decisions
  // ------------------------------------------------------------------
  logic                       pd_s1_ff, pd_s2_ff;
  logic                       nxt_pd_s1, nxt_pd_s2;
  logic                       pd_all;
  logic [3:0]                 cnt_a, cnt_b;
  logic [2:0]                 flen;
  logic                       single_fmt;
  logic [15:0]                nxt_lane_power;
  logic [15:0]                in_use;

  always_comb begin
    nxt_pd_s1 = full_powerdown_pin;
    nxt_pd_s2 = pd_s1_ff;
  end

  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      pd_s1_ff <= 1'b1;
      pd_s2_ff <= 1'b1;
    end else begin
      pd_s1_ff <= nxt_pd_s1;
      pd_s2_ff <= nxt_pd_s2;
    end
  end

  always_comb begin
    pd_all = pd_s2_ff
          || (cfg.op_state_select != `OPST_NORMAL
              && cfg.op_state_select != `OPST_ALT);
    single_fmt = (cfg.lane_format_select == `FMT_8B_SINGLE_16L);
    unique case (cfg.lane_format_select)
      `FMT_12B_D4_16L:    begin cnt_a = `LANES_8; cnt_b = `LANES_8; flen = `FLEN_8; end
      `FMT_15B_D8_2L:     begin cnt_a = `LANES_1; cnt_b = `LANES_1; flen = `FLEN_4; end
      `FMT_15B_D8_4L:     begin cnt_a = `LANES_2; cnt_b = `LANES_2; flen = `FLEN_2; end
      `FMT_15B_D16_1L:    begin cnt_a = `LANES_1; cnt_b = `LANES_0; flen = `FLEN_8; end
      `FMT_15B_D16_2L:    begin cnt_a = `LANES_1; cnt_b = `LANES_1; flen = `FLEN_4; end
      `FMT_8B_SINGLE_16L: begin cnt_a = `LANES_8; cnt_b = `LANES_8; flen = `FLEN_1; end
      `FMT_8B_DUAL_16L:   begin cnt_a = `LANES_8; cnt_b = `LANES_8; flen = `FLEN_1; end
      default:            begin cnt_a = `LANES_0; cnt_b = `LANES_0; flen = `FLEN_1; end
    endcase
  end

  // Power depends on format, keep-alive and power-downs, never on the pattern
  // One continuous driver per bit, so no two processes write one bit
  for (genvar l = 0; l < 16; l++) begin : g_pwr
    localparam logic [3:0] K = 4'(l % 8);
    localparam bit         LB = (l >= 8);
    assign in_use[l] = LB ? (K < cnt_b) : (K < cnt_a);
    assign nxt_lane_power[l] = !pd_all
      && !(LB ? cfg.channel_b_powerdown : cfg.channel_a_powerdown)
      && (in_use[l] || (LB ? cfg.link_b_spare_lane_keepalive
                           : cfg.link_a_spare_lane_keepalive));
  end

  // ------------------------------------------------------------------
  // Frame sequencing
  // ------------------------------------------------------------------
  lane_framer_pkg::run_state_t state_ff, nxt_state;
  logic [2:0]                  oct_ff, nxt_oct, ph_ff, nxt_ph;
  logic                        nxt_take, nxt_start;
  logic                        take_d_ff, nxt_take_d;
  logic [3:0]                  tp_ff, nxt_tp;
  logic                        reseed;
  lane_framer_pkg::frame_in_t  frame_ff, nxt_frame;

  always_comb begin
    nxt_state = state_ff;
    nxt_oct   = oct_ff;
    case (state_ff)
      lane_framer_pkg::ST_DOWN: begin
        nxt_oct = 3'h0;
        if (!pd_all) begin
          nxt_state = lane_framer_pkg::ST_RUN;
        end
      end
      lane_framer_pkg::ST_RUN: begin
        nxt_oct = (oct_ff >= flen) ? 3'h0 : oct_ff + 3'h1;
        if (pd_all) begin
          nxt_state = lane_framer_pkg::ST_DOWN;
          nxt_oct   = 3'h0;
        end
      end
      default: nxt_state = lane_framer_pkg::ST_DOWN;
    endcase
    nxt_take  = (nxt_state == lane_framer_pkg::ST_RUN) && (nxt_oct == 3'h0);
    nxt_ph    = oct_ff;
    // Octet 0 leaves two edges after the take strobe, once frame_ff holds the frame
    nxt_take_d = frame_take_ff;
    nxt_start  = take_d_ff;
    nxt_tp    = cfg.test_pattern_select;
    // Entering a pattern or leaving power-down restarts every generator
    reseed    = (nxt_tp != tp_ff) || (state_ff == lane_framer_pkg::ST_DOWN);
    nxt_frame = frame_ff;
    if (frame_take_ff) begin
      nxt_frame = frame_in;
      // Binding copies one channel onto the other path; not for single channel
      if (cfg.channel_a_route_select && !single_fmt) begin
        nxt_frame.bi = frame_in.ai;
        nxt_frame.bq = frame_in.aq;
      end else if (cfg.channel_b_route_select && !single_fmt) begin
        nxt_frame.ai = frame_in.bi;
        nxt_frame.aq = frame_in.bq;
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      state_ff      <= lane_framer_pkg::ST_DOWN;
      oct_ff        <= 3'h0;
      ph_ff         <= 3'h0;
      frame_take_ff <= 1'b0;
      take_d_ff     <= 1'b0;
      tp_ff         <= `TP_NONE;
      frame_ff      <= '0;
    end else begin
      state_ff      <= nxt_state;
      oct_ff        <= nxt_oct;
      ph_ff         <= nxt_ph;
      frame_take_ff <= nxt_take;
      take_d_ff     <= nxt_take_d;
      tp_ff         <= nxt_tp;
      frame_ff      <= nxt_frame;
    end
  end

  // ------------------------------------------------------------------
  // Ramp counter, shared by all lanes
  // ------------------------------------------------------------------
  logic [7:0] ramp_ff, nxt_ramp;

  always_comb begin
    nxt_ramp = (ila_done && !reseed) ? ramp_ff + `RAMP_STEP : `RAMP_START;
  end

  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      ramp_ff <= `RAMP_START;
    end else begin
      ramp_ff <= nxt_ramp;
    end
  end

  // ------------------------------------------------------------------
  // Per-lane mapping and PRBS
  // ------------------------------------------------------------------
  lane_framer_pkg::lane_octets_t nxt_lane_data;

  for (genvar l = 0; l < 16; l++) begin : g_lane
    localparam int K  = l % 8;
    localparam bit LB = (l >= 8);
    localparam int M  = K / 2;
    logic [22:0] lfsr_ff, nxt_lfsr;
    logic [7:0]  prbs_oct;
    logic [63:0] word, shifted;
    logic [7:0]  data_oct;
    logic [7:0]  lane_oct;
    logic [19:0][15:0] s_i, s_q;

    // Unencoded bits, first bit of the octet in the MSB
    always_comb begin
      logic bitv;
      bitv     = 1'b0;
      nxt_lfsr = lfsr_ff;
      prbs_oct = 8'h00;
      for (int b = 0; b < 8; b++) begin
        case (tp_ff)
          `TP_PRBS7:  bitv = nxt_lfsr[5] ^ nxt_lfsr[6];
          `TP_PRBS15: bitv = nxt_lfsr[13] ^ nxt_lfsr[14];
          default:    bitv = nxt_lfsr[17] ^ nxt_lfsr[22];
        endcase
        nxt_lfsr = {nxt_lfsr[21:0], bitv};
        prbs_oct = {prbs_oct[6:0], bitv};
      end
      if (reseed) begin
        nxt_lfsr = 23'h000001 + 23'(l) * `PRBS_SEED_STEP;
      end
    end

    always_ff @(posedge clk_sys) begin
      if (!nrst) begin
        lfsr_ff <= 23'h000001 + 23'(l) * `PRBS_SEED_STEP;
      end else begin
        lfsr_ff <= nxt_lfsr;
      end
    end

    always_comb begin
      s_i  = LB ? frame_ff.bi : frame_ff.ai;
      s_q  = LB ? frame_ff.bq : frame_ff.aq;
      word = 64'h0;
      case (cfg.lane_format_select)
        `FMT_12B_D4_16L: begin
          word = (K % 2 == 0)
            ? {s_i[M][15:4], s_i[M+4][15:4], s_i[M+8][15:4],
               s_i[M+12][15:4], s_i[M+16][15:4], `TAIL_NIBBLE}
            : {s_q[M][15:4], s_q[M+4][15:4], s_q[M+8][15:4],
               s_q[M+12][15:4], s_q[M+16][15:4], `TAIL_NIBBLE};
        end
        `FMT_15B_D8_2L, `FMT_15B_D16_2L: begin
          word = {s_i[0] & `S15_MASK, s_q[0] & `S15_MASK, 32'h0};
        end
        `FMT_15B_D8_4L: begin
          word = {((K == 0) ? s_i[0] : s_q[0]) & `S15_MASK, 48'h0};
        end
        `FMT_15B_D16_1L: begin
          word = {frame_ff.ai[0] & `S15_MASK, frame_ff.aq[0] & `S15_MASK,
                  frame_ff.bi[0] & `S15_MASK, frame_ff.bq[0] & `S15_MASK};
        end
        `FMT_8B_SINGLE_16L: begin
          word = {frame_ff.ai[2*K + (LB ? 1 : 0)][15:8], 56'h0};
        end
        `FMT_8B_DUAL_16L: begin
          word = {s_i[K][15:8], 56'h0};
        end
        default: word = 64'h0;
      endcase
      shifted  = word << {ph_ff, 3'b000};
      data_oct = shifted[63:56];
      if (!nxt_lane_power[l] || state_ff != lane_framer_pkg::ST_RUN) begin
        lane_oct = 8'h00;
      end else if (!in_use[l]) begin
        lane_oct = `SPARE_OCTET;
      end else begin
        case (tp_ff)
          `TP_PRBS7, `TP_PRBS15, `TP_PRBS23: lane_oct = prbs_oct;
          `TP_RAMP: lane_oct = ramp_ff;
          default:  lane_oct = data_oct;
        endcase
      end
    end

    assign nxt_lane_data[l] = lane_oct;
  end

  // ------------------------------------------------------------------
  // Output registers
  // ------------------------------------------------------------------
  logic [1:0] nxt_conv;

  always_comb begin
    nxt_conv = {!pd_all && !cfg.channel_b_powerdown,
                !pd_all && !cfg.channel_a_powerdown};
  end

  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      lane_data_ff    <= '0;
      lane_power_ff   <= 16'h0000;
      frame_start_ff  <= 1'b0;
      conv_power_ff   <= 2'b00;
      ddc_b_from_a_ff <= 1'b0;
      ddc_a_from_b_ff <= 1'b0;
    end else begin
      lane_data_ff    <= nxt_lane_data;
      lane_power_ff   <= nxt_lane_power;
      frame_start_ff  <= nxt_start;
      conv_power_ff   <= nxt_conv;
      ddc_b_from_a_ff <= cfg.channel_a_route_select;
      ddc_a_from_b_ff <= cfg.channel_b_route_select && !cfg.channel_a_route_select;
    end
  end

  // ------------------------------------------------------------------
  // Assertions
  // ------------------------------------------------------------------
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!nrst);

  logic prbs_run;
  assign prbs_run = lane_power_ff[0] && in_use[0] && state_ff == lane_framer_pkg::ST_RUN;

  pin_pd_off_a: assert property (full_powerdown_pin [*3] |=> lane_power_ff == 16'h0000)
    else $error("lanes powered after power-down pin");
  opst_off_a: assert property (!(cfg.op_state_select inside {`OPST_NORMAL, `OPST_ALT})
      |=> lane_power_ff == 16'h0000)
    else $error("lanes powered in off operating state");
  chan_pd_a: assert property (cfg.channel_a_powerdown
      |=> lane_power_ff[7:0] == 8'h00 && !conv_power_ff[0])
    else $error("channel A power-down ignored");
  unused_lane_a: assert property (!cfg.link_a_spare_lane_keepalive
      |=> (lane_power_ff[7:0] >> $past(cnt_a)) == 8'h00)
    else $error("unused link A lane powered");
  prbs7_rec_a: assert property ((tp_ff == `TP_PRBS7 && !reseed && prbs_run)[*3]
      |-> lane_data_ff[0] == ({$past(lane_data_ff[0][5:0]), lane_data_ff[0][7:6]}
                            ^ {$past(lane_data_ff[0][6:0]), lane_data_ff[0][7]}))
    else $error("PRBS7 recurrence broken");
  prbs23_rec_a: assert property ((tp_ff == `TP_PRBS23 && !reseed && prbs_run)[*5]
      |-> lane_data_ff[0] == ({$past(lane_data_ff[0][1:0], 3), $past(lane_data_ff[0][7:2], 2)}
                            ^ {$past(lane_data_ff[0][6:0], 3), $past(lane_data_ff[0][7], 2)}))
    else $error("PRBS23 recurrence broken");
  ramp_step_a: assert property ((tp_ff == `TP_RAMP && ila_done && !reseed && prbs_run)[*2]
      |=> lane_data_ff[0] == $past(lane_data_ff[0]) + `RAMP_STEP)
    else $error("ramp did not step by one");
  ramp_same_a: assert property (tp_ff == `TP_RAMP && nxt_lane_power[0] && nxt_lane_power[1]
      && in_use[0] && in_use[1] && state_ff == lane_framer_pkg::ST_RUN
      |=> lane_data_ff[1] == lane_data_ff[0])
    else $error("ramp differs between lanes");
  dual8_map_a: assert property (cfg.lane_format_select == `FMT_8B_DUAL_16L
      && tp_ff == `TP_NONE && nxt_lane_power[11] && state_ff == lane_framer_pkg::ST_RUN
      |=> lane_data_ff[11] == $past(frame_ff.bi[3][15:8]))
    else $error("dual 8-bit lane map wrong");
  one_lane_map_a: assert property (cfg.lane_format_select == `FMT_15B_D16_1L
      && tp_ff == `TP_NONE && ph_ff == 3'h4 && nxt_lane_power[0]
      && state_ff == lane_framer_pkg::ST_RUN
      |=> lane_data_ff[0] == $past(frame_ff.bi[0][15:8]))
    else $error("single-lane frame order wrong");

  prbs7_run_c: cover property ((tp_ff == `TP_PRBS7 && prbs_run)[*4]);
  ramp_run_c:  cover property ((tp_ff == `TP_RAMP && ila_done && prbs_run)[*4]);
  frame12_c:   cover property (cfg.lane_format_select == `FMT_12B_D4_16L && frame_start_ff);
  pin_pd_c:    cover property (full_powerdown_pin ##3 lane_power_ff == 16'h0000);

endmodule // lane_framer

// *** hdl/lane_framer_consts.svh ***
// Constants for the lane framer: format codes, frame shapes, pattern codes.
// Assumes inclusion by the framer only.
`ifndef LANE_FRAMER_CONSTS_SVH
`define LANE_FRAMER_CONSTS_SVH

// Lane format codes
`define FMT_12B_D4_16L    5'h0c
`define FMT_15B_D8_2L     5'h0d
`define FMT_15B_D8_4L     5'h0e
`define FMT_15B_D16_1L    5'h0f
`define FMT_15B_D16_2L    5'h10
`define FMT_8B_SINGLE_16L 5'h11
`define FMT_8B_DUAL_16L   5'h12

// Frame length in octets minus one
`define FLEN_8            3'h7
`define FLEN_4            3'h3
`define FLEN_2            3'h1
`define FLEN_1            3'h0

// Lanes in use per link
`define LANES_8           4'h8
`define LANES_2           4'h2
`define LANES_1           4'h1
`define LANES_0           4'h0

// Operating-state values that keep the serializers up
`define OPST_NORMAL       8'h00
`define OPST_ALT          8'h01

// Test-pattern select codes
`define TP_NONE           4'h0
`define TP_PRBS7          4'h1
`define TP_PRBS15         4'h2
`define TP_PRBS23         4'h3
`define TP_RAMP           4'h4

// Sample packing, spare-lane octet, ramp and PRBS seed values
`define TAIL_NIBBLE       4'h0
`define S15_MASK          16'hfffe
`define SPARE_OCTET       8'h55
`define RAMP_START        8'h00
`define RAMP_STEP         8'h01
`define PRBS_SEED_STEP    23'h000005

`endif

// *** hdl/lane_framer_pkg.sv ***
// Types shared by the lane framer and its surroundings.
// Assumes lane_framer_consts.svh sits beside it.
package lane_framer_pkg;

  // Samples of one frame; 16-bit left-aligned words per stream
  typedef struct packed {
    logic [19:0][15:0] ai;
    logic [19:0][15:0] aq;
    logic [19:0][15:0] bi;
    logic [19:0][15:0] bq;
  } frame_in_t;

  // Host configuration fields
  typedef struct packed {
    logic [4:0] lane_format_select;
    logic [3:0] test_pattern_select;
    logic [7:0] op_state_select;
    logic       channel_a_route_select;
    logic       channel_b_route_select;
    logic       channel_a_powerdown;
    logic       channel_b_powerdown;
    logic       link_a_spare_lane_keepalive;
    logic       link_b_spare_lane_keepalive;
  } cfg_t;

  // Lanes 0..7 are link A, 8..15 are link B
  typedef logic [15:0][7:0] lane_octets_t;

  typedef enum logic {ST_DOWN, ST_RUN} run_state_t;

endpackage

// *** verification/lane_framer_bench.sv ***
// Self-checking bench for lane_framer with a receiver model on the lanes.
// Assumes the framer package is compiled first; inputs change on falling edges.
`timescale 1ns/1ps
module lane_framer_bench;
  logic                          clk_sys, nrst, full_powerdown_pin, link_en, ila_done, chk_on;
  logic                          frame_take_ff, frame_start_ff, ddc_b_from_a_ff, ddc_a_from_b_ff;
  logic [1:0]                    conv_power_ff;
  logic [15:0]                   lane_power_ff;
  lane_framer_pkg::cfg_t         cfg;
  lane_framer_pkg::frame_in_t    frame_in, cur;
  lane_framer_pkg::frame_in_t    q[$];
  lane_framer_pkg::lane_octets_t lane_data_ff;
  int                            failures, checks, seed, cycles, oct;

  lane_framer dut_u (.clk_sys(clk_sys), .nrst(nrst), .cfg(cfg),
    .full_powerdown_pin(full_powerdown_pin), .ila_done(ila_done), .frame_in(frame_in),
    .frame_take_ff(frame_take_ff), .lane_data_ff(lane_data_ff), .lane_power_ff(lane_power_ff),
    .frame_start_ff(frame_start_ff), .conv_power_ff(conv_power_ff),
    .ddc_b_from_a_ff(ddc_b_from_a_ff), .ddc_a_from_b_ff(ddc_a_from_b_ff));

  lane_receiver_model rx_u (.clk_sys(clk_sys), .nrst(nrst), .link_en(link_en),
    .lane_power(lane_power_ff), .ila_done(ila_done));

  // ----
  // Expectations
  // ----
  function automatic int lanes_in(input logic [4:0] f, input bit lb);
    case (f)
      5'h0c, 5'h11, 5'h12: return 8;
      5'h0d, 5'h10: return 1;
      5'h0e: return 2;
      5'h0f: return lb ? 0 : 1;
      default: return 0;
    endcase
  endfunction

  function automatic int flen(input logic [4:0] f);
    case (f)
      5'h0c, 5'h0f: return 8;
      5'h0d, 5'h10: return 4;
      5'h0e: return 2;
      default: return 1;
    endcase
  endfunction

  function automatic logic [15:0] pw_exp(input lane_framer_pkg::cfg_t c, input logic p);
    logic [7:0] ma, mb;
    ma = c.link_a_spare_lane_keepalive ? 8'hff : 8'((1 << lanes_in(c.lane_format_select, 0)) - 1);
    mb = c.link_b_spare_lane_keepalive ? 8'hff : 8'((1 << lanes_in(c.lane_format_select, 1)) - 1);
    if (c.channel_a_powerdown) ma = 8'h00;
    if (c.channel_b_powerdown) mb = 8'h00;
    if (p || c.op_state_select > 8'h01) return 16'h0000;
    return {mb, ma};
  endfunction

  function automatic logic [7:0] lane_exp(input int l, input int o);
    logic [19:0][15:0] si, sq;
    logic [15:0]       pw;
    logic [63:0]       w;
    logic              sa;
    int                k;
    k = l % 8;
    pw = pw_exp(cfg, full_powerdown_pin);
    sa = (l < 8) ? (cfg.channel_a_route_select || !cfg.channel_b_route_select)
                 : cfg.channel_a_route_select;
    si = sa ? cur.ai : cur.bi;
    sq = sa ? cur.aq : cur.bq;
    if (k % 2 == 1 && cfg.lane_format_select inside {5'h0c, 5'h0e}) si = sq;
    case (cfg.lane_format_select)
      5'h0c: w = {si[k/2][15:4], si[k/2+4][15:4], si[k/2+8][15:4], si[k/2+12][15:4],
                  si[k/2+16][15:4], 4'h0};
      5'h0d, 5'h10: w = {si[0] & 16'hfffe, sq[0] & 16'hfffe, 32'h0};
      5'h0e: w = {si[0] & 16'hfffe, 48'h0};
      5'h0f: w = {cur.ai[0] & 16'hfffe, cur.aq[0] & 16'hfffe, cur.bi[0] & 16'hfffe,
                  cur.bq[0] & 16'hfffe};
      5'h11: w = {cur.ai[2*k + l/8][15:8], 56'h0};
      default: w = {si[k][15:8], 56'h0};
    endcase
    if (!pw[l]) return 8'h00;
    if (k >= lanes_in(cfg.lane_format_select, l >= 8)) return 8'h55;
    return w[63 - 8*o -: 8];
  endfunction

  task automatic check(input logic [63:0] seen, input logic [63:0] exp);
    checks++;
    if (seen !== exp) begin
      failures++;
      $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic end_of_test();
    if (failures == 0 && checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask

  // ----
  // Stimulus and monitors
  // ----
  initial begin
    clk_sys = 1'b0;
    forever #50 clk_sys = ~clk_sys;
  end

  always @(negedge clk_sys) begin
    for (int i = 0; i < 40; i++) frame_in[i*32 +: 32] = $random(seed);
  end

  always @(posedge clk_sys) begin
    cycles++;
    if (!nrst) q.delete();
    else if (frame_take_ff === 1'b1) q.push_back(frame_in);
    if (cycles == 8000) begin
      failures++;
      end_of_test();
    end
  end

  // Frames are compared octet by octet against the frame taken one edge earlier
  always @(negedge clk_sys) begin
    if (frame_start_ff === 1'b1 && q.size() > 0) begin
      cur = q.pop_front();
      oct = 0;
    end else begin
      oct++;
    end
    if (chk_on && oct < flen(cfg.lane_format_select)) begin
      check(64'(lane_power_ff), 64'(pw_exp(cfg, full_powerdown_pin)));
      for (int l = 0; l < 16; l++) begin
        check(64'(lane_data_ff[l]), 64'(lane_exp(l, oct)));
      end
    end
  end

  task automatic run_fmt(input logic [4:0] f, input logic [3:0] opt);
    nrst = 1'b0;
    cfg = '0;
    cfg.lane_format_select = f;
    {cfg.channel_b_powerdown, cfg.channel_a_powerdown} = opt[3:2];
    {cfg.channel_b_route_select, cfg.channel_a_route_select} = opt[1:0];
    if (opt == 4'h0) begin
      {cfg.link_b_spare_lane_keepalive, cfg.link_a_spare_lane_keepalive} = 2'($random(seed));
    end
    repeat (3) @(negedge clk_sys);
    nrst = 1'b1;
    repeat (8) @(negedge clk_sys);
    chk_on <= 1'b1;
    repeat (40) @(negedge clk_sys);
    chk_on <= 1'b0;
    // Let the monitor see chk_on low before the next scenario touches cfg
    @(negedge clk_sys);
    check(64'(conv_power_ff), 64'({~opt[3], ~opt[2]}));
    if (f != 5'h11) begin
      check(64'({ddc_b_from_a_ff, ddc_a_from_b_ff}),
            64'({opt[0], opt[1] & ~opt[0]}));
    end
  endtask

  task automatic pw_step(input logic p, input logic [7:0] st, input int lat);
    full_powerdown_pin = p;
    cfg.op_state_select = st;
    repeat (lat) @(negedge clk_sys);
    check(64'(lane_power_ff), 64'(pw_exp(cfg, p)));
    if (pw_exp(cfg, p) == 16'h0000) check(64'(|lane_data_ff), 64'h0);
  endtask

  // Patterns run on format 12 so that all sixteen lanes carry one
  task automatic pat_run(input logic [3:0] tp, input int t1, input int t2);
    logic [15:0][63:0] s;
    logic [63:0]       e;
    int                n;
    link_en = 1'b0;
    cfg.test_pattern_select = tp;
    repeat (4) @(negedge clk_sys);
    if (tp == 4'h4) begin
      check(64'(lane_data_ff[0]), 64'h0);
      link_en = 1'b1;
      n = 0;
      while (lane_data_ff[0] !== 8'hfc && n < 400) begin
        @(negedge clk_sys);
        n++;
      end
    end
    for (int i = 0; i < 8; i++) begin
      for (int l = 0; l < 16; l++) s[l][63 - 8*i -: 8] = lane_data_ff[l];
      @(negedge clk_sys);
    end
    check(64'(lane_power_ff), 64'(pw_exp(cfg, 1'b0)));
    for (int l = 0; l < 16; l++) begin
      e = '0;
      if (tp == 4'h4) begin
        for (int i = 0; i < 8; i++) e[63 - 8*i -: 8] = 8'hfc + 8'(i);
        check(s[l], e);
      end else begin
        for (int b = t2; b < 64; b++) e[b] = s[l][63-b] ^ s[l][63-b+t1] ^ s[l][63-b+t2];
        check(e, 64'h0);
        check(64'(s[l] == s[(l + 1) % 16]), 64'h0);
        check(64'(s[l] == 64'h0), 64'h0);
      end
    end
  endtask

  initial begin
    seed = 39;
    failures = 0;
    checks = 0;
    cycles = 0;
    oct = 99;
    nrst = 1'b0;
    full_powerdown_pin = 1'b0;
    link_en = 1'b0;
    chk_on = 1'b0;
    cfg = '0;
    frame_in = '0;
    repeat (8) @(negedge clk_sys);
    check(64'({lane_power_ff, conv_power_ff, frame_take_ff, |lane_data_ff}), 64'h0);
    for (int f = 12; f <= 18; f++) run_fmt(5'(f), 4'h0);
    run_fmt(5'h0c, 4'h4);
    run_fmt(5'h12, 4'h1);
    run_fmt(5'h12, 4'h2);
    run_fmt(5'h11, 4'h1);
    run_fmt(5'h12, 4'h9);
    run_fmt(5'h0c, 4'h0);
    pw_step(1'b0, 8'h02, 1);
    pw_step(1'b0, 8'h01, 1);
    pw_step(1'b0, 8'hff, 1);
    pw_step(1'b1, 8'h00, 3);
    pw_step(1'b0, 8'h00, 3);
    pat_run(4'h1, 6, 7);
    pat_run(4'h2, 14, 15);
    pat_run(4'h3, 18, 23);
    pat_run(4'h4, 0, 0);
    end_of_test();
  end
endmodule // lane_framer_bench

// *** verification/lane_receiver_model.sv ***
// Behavioural receiver at the far end of the serial lanes.
// Assumes the framer's clock and a bench that enables the link.
`timescale 1ns/1ps
module lane_receiver_model #(
  parameter int ALIGN_CYCLES = 6
) (
  // Clock and reset
  input  wire logic        clk_sys,
  input  wire logic        nrst,
  // Link control and lane status
  input  wire logic        link_en,
  input  wire logic [15:0] lane_power,
  // Alignment report
  output logic             ila_done
);
  int unsigned wait_cnt_ff;

  // Losing every lane drops the link, so data from before a power-down is never taken
  always_ff @(posedge clk_sys) begin
    if (!nrst || !link_en || lane_power == 16'h0000) begin
      wait_cnt_ff <= 0;
      ila_done    <= 1'b0;
    end else if (wait_cnt_ff < ALIGN_CYCLES) begin
      wait_cnt_ff <= wait_cnt_ff + 1;
    end else begin
      ila_done <= 1'b1;
    end
  end
endmodule // lane_receiver_model
